/* osc_pkg.sv */
// Package of constants, types and register layout for the oscillator select control
//
// How it works
// - The current-source field is read only and shows which of the eight coded sources drives the core.
// - Software writes the new-source field, coded like the current-source field, to pick the target source.
// - After power-on reset the new-source field is loaded from the configuration settings input, not a constant.
// - With the clock lock bit set and clock monitor config bit 0 high, clock and PLL settings refuse changes.
// - The pin-mapping lock bit is writable and, when one, asserts the I/O lock output.
// - The PLL lock status reads one when the PLL is enabled and either locked or its start-up timer expired, else zero.
// - Writing one to the clock-fail flag acts as a real oscillator failure and raises the failure trap.
// - Writes to the oscillator control register are taken only right after the unlock key sequence.
// - Switches straight between primary-with-PLL and fast-RC-with-PLL are refused; go through plain fast RC.
// - Unimplemented bits of the oscillator control register, bits 15 and 11 among them, read as zero.
// - The reference clock module is off while its disable bit in module disable register four is one.
package osc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] OSC_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] OSC_ADDR_KEY    = 4'h1;
	localparam logic [3:0] OSC_ADDR_MODDIS = 4'h2;
	localparam logic [3:0] OSC_ADDR_STATUS = 4'h3;
	localparam logic [3:0] OSC_ADDR_MASK   = 4'h4;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int OSC_CUR_LSB    = 12;
	localparam int OSC_NEW_LSB    = 8;
	localparam int OSC_CLKLK_BIT  = 7;
	localparam int OSC_IOLK_BIT   = 6;
	localparam int OSC_PLLLK_BIT  = 5;
	localparam int OSC_FAIL_BIT   = 3;
	localparam int OSC_SWREQ_BIT  = 0;
	localparam int OSC_REFOFF_BIT = 3;

	// Interrupt status bits
	localparam int OSC_IRQ_DONE   = 0;
	localparam int OSC_IRQ_FAIL   = 1;
	localparam int OSC_IRQ_REFUSE = 2;
	localparam int OSC_IRQ_W      = 3;

	// ----------------------------------------
	// Unlock keys, reset values and timing
	// ----------------------------------------
	localparam logic [15:0] OSC_KEY1      = 16'h0078;
	localparam logic [15:0] OSC_KEY2      = 16'h009A;
	localparam logic [2:0]  OSC_CUR_RESET = 3'h0;
	localparam logic [15:0] OSC_PMD_RESET = 16'h0000;
	localparam int          OSC_SW_NS     = 200;
	localparam int          OSC_CLK_NS    = 20;
	localparam int          OSC_SW_CYC    = (OSC_SW_NS + OSC_CLK_NS - 1) / OSC_CLK_NS;

	// ----------------------------------------
	// Source codes and types
	// ----------------------------------------
	typedef enum logic [2:0] {
		OSC_SRC_FAST    = 3'h0,
		OSC_SRC_FASTPLL = 3'h1,
		OSC_SRC_PRI     = 3'h2,
		OSC_SRC_PRIPLL  = 3'h3,
		OSC_SRC_RSVD    = 3'h4,
		OSC_SRC_LOWPWR  = 3'h5,
		OSC_SRC_FAST16  = 3'h6,
		OSC_SRC_FASTN   = 3'h7
	} osc_src_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} osc_bus_t;

endpackage

/* osc_unlock.sv */
// Unlock key sequence detector
`timescale 1ns/1ps
`default_nettype none
module osc_unlock
	import osc_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     reset,
	input  wire osc_bus_t bus,
	output logic          open_now
);
	logic [1:0] stage_q;

	// ----------------------------------------
	// Key stage tracking
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			stage_q <= 2'h0;
		else if (bus.wr && bus.addr == OSC_ADDR_KEY && bus.wdata == OSC_KEY1)
			stage_q <= 2'h1;
		else if (bus.wr && bus.addr == OSC_ADDR_KEY && bus.wdata == OSC_KEY2 && stage_q == 2'h1)
			stage_q <= 2'h2;
		else if (bus.wr || bus.rd)
			stage_q <= 2'h0;
	end

	assign open_now = (stage_q == 2'h2);
endmodule
`default_nettype wire

/* osc_switch.sv */
// Clock switch sequencer
`timescale 1ns/1ps
`default_nettype none
module osc_switch
	import osc_pkg::*;
#(
	parameter int SW_CYC = OSC_SW_CYC
)
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic [2:0] target,
	output logic            busy,
	output logic            done,
	output logic [2:0]      current
);
	typedef enum {ST_IDLE, ST_WAIT} osc_sw_state_t;
	osc_sw_state_t state_q;
	logic [7:0]    cnt_q;
	logic [2:0]    tgt_q;

	// ----------------------------------------
	// Switch sequence
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			tgt_q   <= OSC_CUR_RESET;
			current <= OSC_CUR_RESET;
			done    <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (start)
					begin
						tgt_q   <= target;
						cnt_q   <= 8'(SW_CYC - 1);
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (cnt_q == 8'h00)
					begin
						current <= tgt_q;
						done    <= 1'b1;
						state_q <= ST_IDLE;
					end
					else
						cnt_q <= cnt_q - 8'h01;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	assign busy = (state_q == ST_WAIT);
endmodule
`default_nettype wire

/* osc_ctrl.sv */
// Oscillator select control: registers, locks, failure trap and switch start
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl
	import osc_pkg::*;
#(
	parameter int SW_CYC = OSC_SW_CYC
)
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        por,
	input  wire logic [2:0]  cfg_new_source,
	input  wire logic        clock_monitor_cfg0,
	input  wire logic        pll_locked,
	input  wire logic        pll_timer_done,
	input  wire logic        pll_enabled,
	input  wire logic        osc_fail_in,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata,
	output logic             osc_fail_trap,
	output logic             pin_mapping_lock_out,
	output logic             refclk_enable,
	output logic [2:0]       clock_source,
	output logic             irq
);
	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	osc_bus_t   bus;
	logic       open_now;
	logic       busy;
	logic       done;
	logic [2:0] current_source_sel;
	logic [2:0] new_source_sel_q;
	logic       clock_config_lock_q;
	logic       pin_mapping_lock_q;
	logic       clock_fail_flag_q;
	logic       switch_request_q;
	logic       refclk_module_off_q;
	logic [OSC_IRQ_W-1:0] status_q;
	logic [OSC_IRQ_W-1:0] mask_q;
	logic       ctrl_wr;
	logic       cfg_locked;
	logic       sw_start;
	logic       forbidden;
	logic       pll_status;
	logic       fail_set;
	logic       refuse_event;
	logic       status_wr;
	logic       mask_wr;
	logic       moddis_wr;
	logic [15:0] rd_word;
	logic [OSC_IRQ_W-1:0] status_set;

	assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

	// ----------------------------------------
	// Key detector and switch sequencer
	// ----------------------------------------
	osc_unlock u_unlock (
		.clk      (clk),
		.reset    (reset),
		.bus      (bus),
		.open_now (open_now)
	);

	osc_switch #(.SW_CYC(SW_CYC)) u_switch (
		.clk     (clk),
		.reset   (reset),
		.start   (sw_start),
		.target  (new_source_sel_q),
		.busy    (busy),
		.done    (done),
		.current (current_source_sel)
	);

	// ----------------------------------------
	// Write qualification
	// ----------------------------------------
	assign ctrl_wr      = wr && addr == OSC_ADDR_CTRL && open_now;
	assign cfg_locked   = clock_config_lock_q && clock_monitor_cfg0;
	assign forbidden    = (current_source_sel == OSC_SRC_PRIPLL
	                    && new_source_sel_q == OSC_SRC_FASTPLL)
	                   || (current_source_sel == OSC_SRC_FASTPLL
	                    && new_source_sel_q == OSC_SRC_PRIPLL);
	assign sw_start     = switch_request_q && !busy && !done && !forbidden && !cfg_locked;
	assign refuse_event = switch_request_q && !busy && !done && forbidden;
	assign pll_status   = pll_enabled && (pll_locked || pll_timer_done);
	assign fail_set     = osc_fail_in || (ctrl_wr && wdata[OSC_FAIL_BIT]);
	assign status_wr    = wr && addr == OSC_ADDR_STATUS;
	assign mask_wr      = wr && addr == OSC_ADDR_MASK;
	assign moddis_wr    = wr && addr == OSC_ADDR_MODDIS;

	// ----------------------------------------
	// Oscillator control register
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			new_source_sel_q <= OSC_CUR_RESET;
		else if (por)
			new_source_sel_q <= cfg_new_source;
		else if (ctrl_wr && !cfg_locked)
			new_source_sel_q <= wdata[OSC_NEW_LSB +: 3];
	end

	// ----------------------------------------
	// Clock lock
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			clock_config_lock_q <= 1'b0;
		else if (ctrl_wr && !clock_config_lock_q)
			clock_config_lock_q <= wdata[OSC_CLKLK_BIT];
	end

	// ----------------------------------------
	// Pin mapping lock
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			pin_mapping_lock_q <= 1'b0;
		else if (ctrl_wr)
			pin_mapping_lock_q <= wdata[OSC_IOLK_BIT];
	end

	// ----------------------------------------
	// Clock fail flag
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			clock_fail_flag_q <= 1'b0;
		else if (fail_set)
			clock_fail_flag_q <= 1'b1;
		else if (ctrl_wr)
			clock_fail_flag_q <= 1'b0;
	end

	// ----------------------------------------
	// Switch request
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			switch_request_q <= 1'b0;
		else if (ctrl_wr && wdata[OSC_SWREQ_BIT] && !cfg_locked)
			switch_request_q <= 1'b1;
		else if (done || (switch_request_q && !busy && (forbidden || cfg_locked)))
			switch_request_q <= 1'b0;
	end

	// ----------------------------------------
	// Module disable register four
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			refclk_module_off_q <= OSC_PMD_RESET[OSC_REFOFF_BIT];
		else if (moddis_wr)
			refclk_module_off_q <= wdata[OSC_REFOFF_BIT];
	end

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	always_comb
	begin
		status_set                 = '0;
		status_set[OSC_IRQ_DONE]   = done;
		status_set[OSC_IRQ_FAIL]   = fail_set;
		status_set[OSC_IRQ_REFUSE] = refuse_event;
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			status_q <= '0;
		else
		begin
			for (int i = 0; i < OSC_IRQ_W; i++)
			begin
				if (status_set[i])
					status_q[i] <= 1'b1;
				else if (status_wr && wdata[i])
					status_q[i] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Interrupt mask
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			mask_q <= '0;
		else if (mask_wr)
			mask_q <= wdata[OSC_IRQ_W-1:0];
	end

	// ----------------------------------------
	// Failure trap
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			osc_fail_trap <= 1'b0;
		else
			osc_fail_trap <= fail_set;
	end

	// ----------------------------------------
	// Pin mapping lock output
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			pin_mapping_lock_out <= 1'b0;
		else
			pin_mapping_lock_out <= pin_mapping_lock_q;
	end

	// ----------------------------------------
	// Reference clock enable
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			refclk_enable <= 1'b1;
		else
			refclk_enable <= !refclk_module_off_q;
	end

	// ----------------------------------------
	// Current source output
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			clock_source <= OSC_CUR_RESET;
		else
			clock_source <= current_source_sel;
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= |(status_q & mask_q);
	end

	// ----------------------------------------
	// Read word
	// ----------------------------------------
	always_comb
	begin
		rd_word = 16'h0000;
		case (addr)
			OSC_ADDR_CTRL:
			begin
				rd_word[OSC_CUR_LSB +: 3] = current_source_sel;
				rd_word[OSC_NEW_LSB +: 3] = new_source_sel_q;
				rd_word[OSC_CLKLK_BIT]    = clock_config_lock_q;
				rd_word[OSC_IOLK_BIT]     = pin_mapping_lock_q;
				rd_word[OSC_PLLLK_BIT]    = pll_status;
				rd_word[OSC_FAIL_BIT]     = clock_fail_flag_q;
				rd_word[OSC_SWREQ_BIT]    = switch_request_q;
			end
			OSC_ADDR_MODDIS:
				rd_word[OSC_REFOFF_BIT] = refclk_module_off_q;
			OSC_ADDR_STATUS:
				rd_word[OSC_IRQ_W-1:0] = status_q;
			OSC_ADDR_MASK:
				rd_word[OSC_IRQ_W-1:0] = mask_q;
			default:
				rd_word = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			rdata <= 16'h0000;
		else if (rd)
			rdata <= rd_word;
		else
			rdata <= 16'h0000;
	end
endmodule
`default_nettype wire

/* osc_ctrl_props.sv */
// Checker of the oscillator control port relations
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_props
	import osc_pkg::*;
#(
	parameter int SW_CYC = OSC_SW_CYC
)
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        por,
	input wire logic [2:0]  cfg_new_source,
	input wire logic        pll_locked,
	input wire logic        pll_timer_done,
	input wire logic        pll_enabled,
	input wire logic        osc_fail_in,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        osc_fail_trap,
	input wire logic        pin_mapping_lock_out,
	input wire logic        refclk_enable,
	input wire logic [2:0]  clock_source
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence key1_s; wr && addr == OSC_ADDR_KEY && wdata == OSC_KEY1; endsequence
	sequence key2_s; wr && addr == OSC_ADDR_KEY && wdata == OSC_KEY2; endsequence
	sequence ctrl_wr_s; wr && addr == OSC_ADDR_CTRL; endsequence
	rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data not zero outside read");
	ctrl_zero_a: assert property (rd && addr == OSC_ADDR_CTRL |=> (rdata & 16'h8816) == 16'h0000)
		else $error("unused control bits not zero");
	pll_lock_a: assert property (rd && addr == OSC_ADDR_CTRL |=> rdata[OSC_PLLLK_BIT] ==
		$past(pll_enabled && (pll_locked || pll_timer_done))) else $error("pll lock status wrong");
	por_load_a: assert property (por ##2 (rd && addr == OSC_ADDR_CTRL) |=>
		rdata[10:8] == $past(cfg_new_source, 3)) else $error("new source not loaded on power-on");
	fail_trap_a: assert property (osc_fail_in |=> osc_fail_trap)
		else $error("no trap after failure");
	refclk_a: assert property (wr && addr == OSC_ADDR_MODDIS ##1 !(wr && addr == OSC_ADDR_MODDIS)
		|=> refclk_enable == !$past(wdata[OSC_REFOFF_BIT], 2)) else $error("refclk enable wrong");
	unlock_write_a: assert property (key1_s ##1 !(wr || rd) ##1 key2_s ##1 !(wr || rd) ##1
		ctrl_wr_s |=> ##1 pin_mapping_lock_out == $past(wdata[OSC_IOLK_BIT], 2))
		else $error("unlocked write lost");
	write_guard_a: assert property (ctrl_wr_s and (!$past(wr || rd) && $past(wr, 2) &&
		!($past(addr, 2) == OSC_ADDR_KEY && $past(wdata, 2) == OSC_KEY2)) |=> ##1
		$stable(pin_mapping_lock_out)) else $error("locked write taken");
	no_pll_hop_a: assert property ($past(clock_source) == OSC_SRC_PRIPLL
		|-> clock_source != OSC_SRC_FASTPLL) else $error("direct pll to pll switch");
	pll_hop_back_a: assert property ($past(clock_source) == OSC_SRC_FASTPLL
		|-> clock_source != OSC_SRC_PRIPLL) else $error("direct pll to pll switch back");
endmodule
`default_nettype wire

/* osc_ctrl_test.sv */
// Testbench of the oscillator select control
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module osc_ctrl_test
	import osc_pkg::*;
;
	logic        clk = 1'b0, reset = 1'b1, por = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        clock_monitor_cfg0 = 1'b0, osc_fail_in = 1'b0;
	logic        pll_locked = 1'b0, pll_timer_done = 1'b0, pll_enabled = 1'b1;
	logic [2:0]  cfg_new_source = 3'h2;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        osc_fail_trap, pin_mapping_lock_out, refclk_enable, irq;
	logic [2:0]  clock_source;
	int          fail_count = 0, compares = 0, cycles = 0;

	osc_ctrl u_osc_ctrl (.clk(clk), .reset(reset), .por(por), .cfg_new_source(cfg_new_source),
		.clock_monitor_cfg0(clock_monitor_cfg0), .pll_locked(pll_locked),
		.pll_timer_done(pll_timer_done), .pll_enabled(pll_enabled), .osc_fail_in(osc_fail_in),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_fail_trap(osc_fail_trap),
		.pin_mapping_lock_out(pin_mapping_lock_out), .refclk_enable(refclk_enable),
		.clock_source(clock_source), .irq(irq));

	// ----------------------------------------
	// Clock, timeout and bus tasks
	// ----------------------------------------
	initial
	begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [3:0] a, input logic [15:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(n, e, rdata)
	endtask
	task automatic unlock(input logic [15:0] d);
		bus_wr(OSC_ADDR_KEY, OSC_KEY1);
		bus_wr(OSC_ADDR_KEY, OSC_KEY2);
		bus_wr(OSC_ADDR_CTRL, d);
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		bus_rd(OSC_ADDR_CTRL, 16'h0200, "ctrl after por");
		bus_rd(OSC_ADDR_MODDIS, 16'h0000, "pmd reset");
		bus_rd(4'hF, 16'h0000, "unmapped");
		`CHK("refclk on", 1'b1, refclk_enable)
		bus_wr(OSC_ADDR_MASK, 16'h0007);
		bus_wr(OSC_ADDR_KEY, OSC_KEY1);
		bus_wr(OSC_ADDR_KEY, 16'h0055);
		bus_wr(OSC_ADDR_CTRL, 16'h0040);
		bus_wr(OSC_ADDR_CTRL, 16'h0040);
		bus_rd(OSC_ADDR_CTRL, 16'h0200, "ctrl refused");
		unlock(16'h0040);
		bus_rd(OSC_ADDR_CTRL, 16'h0040, "io lock");
		`CHK("io lock out", 1'b1, pin_mapping_lock_out)
		$display("test lock done");
		@(posedge clk);
		pll_timer_done <= 1'b1;
		unlock(16'h0341);
		for (int i = 0; i < 40 && clock_source !== 3'h3; i++) @(posedge clk);
		bus_rd(OSC_ADDR_CTRL, 16'h3360, "switched");
		bus_rd(OSC_ADDR_STATUS, 16'h0001, "done status");
		`CHK("irq done", 1'b1, irq)
		bus_wr(OSC_ADDR_STATUS, 16'h0001);
		bus_rd(OSC_ADDR_STATUS, 16'h0000, "status clear");
		`CHK("irq clear", 1'b0, irq)
		unlock(16'h0141);
		repeat (15) @(posedge clk);
		`CHK("no hop", 3'h3, clock_source)
		bus_rd(OSC_ADDR_CTRL, 16'h3160, "hop refused");
		bus_rd(OSC_ADDR_STATUS, 16'h0004, "refuse status");
		bus_wr(OSC_ADDR_STATUS, 16'h0004);
		$display("test switch done");
		unlock(16'h0348);
		#1 `CHK("sw trap", 1'b1, osc_fail_trap)
		bus_rd(OSC_ADDR_CTRL, 16'h3368, "fail flag");
		bus_rd(OSC_ADDR_STATUS, 16'h0002, "fail status");
		bus_wr(OSC_ADDR_MASK, 16'h0000);
		bus_rd(OSC_ADDR_STATUS, 16'h0002, "masked status");
		`CHK("irq masked", 1'b0, irq)
		bus_wr(OSC_ADDR_MASK, 16'h0007);
		unlock(16'h0340);
		bus_wr(OSC_ADDR_STATUS, 16'h0002);
		@(posedge clk);
		osc_fail_in <= 1'b1;
		@(posedge clk);
		osc_fail_in <= 1'b0;
		#1 `CHK("hw trap", 1'b1, osc_fail_trap)
		$display("test fail done");
		@(posedge clk);
		clock_monitor_cfg0 <= 1'b1;
		unlock(16'h03C0);
		unlock(16'h0041);
		bus_rd(OSC_ADDR_CTRL, 16'h33E0, "clock locked");
		@(posedge clk);
		clock_monitor_cfg0 <= 1'b0;
		unlock(16'h00C0);
		bus_rd(OSC_ADDR_CTRL, 16'h30E0, "lock bypass");
		bus_wr(OSC_ADDR_MODDIS, 16'hFFFF);
		bus_rd(OSC_ADDR_MODDIS, 16'h0008, "pmd bits");
		`CHK("refclk off", 1'b0, refclk_enable)
		$display("test pmd done");
		print_verdict();
	end
endmodule

bind osc_ctrl osc_ctrl_props #(.SW_CYC(SW_CYC)) u_osc_ctrl_props (.clk(clk), .reset(reset),
	.por(por), .cfg_new_source(cfg_new_source), .pll_locked(pll_locked),
	.pll_timer_done(pll_timer_done), .pll_enabled(pll_enabled), .osc_fail_in(osc_fail_in),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_fail_trap(osc_fail_trap),
	.pin_mapping_lock_out(pin_mapping_lock_out), .refclk_enable(refclk_enable),
	.clock_source(clock_source));
`default_nettype wire
